// file: shared/aic_defines.svh
// Constants of the auxiliary I2C master configuration block.
// Assumes one 8-bit register port and a 250 MHz core clock.
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AIC_OFS_FCFG 8'h49
`define AIC_OFS_SLV  8'h4B
`define AIC_OFS_CONF 8'h4C
`define AIC_OFS_RDP  8'h4D
`define AIC_OFS_WRP  8'h4E
`define AIC_OFS_WDAT 8'h4F
`define AIC_OFS_IRQ  8'h53
`define AIC_OFS_STAT 8'h5E
`define AIC_OFS_RBYT 8'h5F
// ----------------------------------------
// Reset values
// ----------------------------------------
`define AIC_RST_FCFG 8'h00
`define AIC_RST_SLV  8'h20
`define AIC_RST_CONF 8'h83
`define AIC_RST_RDP  8'h42
`define AIC_RST_WRP  8'h4C
`define AIC_RST_WDAT 8'h02
`define AIC_RST_IRQ  8'h00
// ----------------------------------------
// Writable field masks
// ----------------------------------------
`define AIC_MSK_FCFG 8'h60
`define AIC_MSK_SLV  8'hFE
`define AIC_MSK_CONF 8'h83
`define AIC_MSK_IRQ  8'h1F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define AIC_B_ACC_EN 6
`define AIC_B_AUX_EN 5
`define AIC_B_MANUAL 7
`define AIC_B_IN_EN  4
`define AIC_B_OUT_EN 3
`define AIC_B_OD     2
`define AIC_B_LVL    1
`define AIC_B_EDGE   0
// ----------------------------------------
// Burst lengths and timing
// ----------------------------------------
`define AIC_BL_1 4'h1
`define AIC_BL_2 4'h2
`define AIC_BL_6 4'h6
`define AIC_BL_8 4'h8
`define AIC_SCL_PERIOD_NS 2500
`define AIC_CLK_PERIOD_NS 4
`define AIC_QTR_CYC ((`AIC_SCL_PERIOD_NS / 4 + `AIC_CLK_PERIOD_NS - 1) / `AIC_CLK_PERIOD_NS)
`endif

// file: shared/aic_pkg.sv
// Types of the auxiliary I2C master configuration block.
// Assumes nothing beyond SystemVerilog packed types.
package aic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_RSTART,
    ST_STOP
  } aic_state_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } aic_acc_t;

  typedef struct packed {
    logic        is_aux;
    logic [63:0] payload;
  } aic_frame_t;
endpackage

// file: src/aic_aux_i2c_cfg.sv
// Auxiliary I2C master with its configuration registers and pin control.
// Assumes a register port on clk_i and an open-drain bus pulled up outside.
`include "aic_defines.svh"

// Function
// R1: With the aux FIFO enable set, aux burst data enter the FIFO, otherwise none; the code queues only data-mode reads that end without a NACK.
// R2: With the accel FIFO enable set, accel samples enter the FIFO, otherwise none.
// R3: The slave address sits in bits 7..1, resets to 0x20 and is used on every transfer.
// R4: Burst codes 0..3 fetch 1, 2, 6 or 8 bytes per aux read.
// R5: The manual bit selects setup mode when set, data mode when clear, and resets to 1.
// R6: The read pointer names the slave register that reads start from, reset 0x42.
// R7: The write pointer names the slave register that writes go to, reset 0x4C.
// R8: The outgoing byte is the data sent on a write, reset 0x02.
// R9: The pin control register holds output enable, drive, polarity, trigger at 3..0, reset 0.
// R10: An input pin is level sensed when the trigger bit is 0 and edge sensed when 1.
// R11: The polarity bit makes the pin active low when 0 and active high when 1.
// R12: The drive bit selects push-pull when 0 and open drain when 1.
// R13: The output enable bit turns the pin driver off when 0 and on when 1.
// R14: Bit 4 of the pin control register accepts the pin as an input when set.
// R15: In setup mode a write of the read pointer or of the outgoing byte starts one transfer.
module aic_aux_i2c_cfg #(
  parameter int QTR_CYC = `AIC_QTR_CYC
) (
  // Clock, reset, enable
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               we_i,
  input  wire logic               re_i,
  output logic      [7:0]         rdata_o,
  // Data mode poll and samples
  input  wire logic               poll_i,
  input  wire logic               acc_valid_i,
  input  wire aic_pkg::aic_acc_t  acc_i,
  output logic                    frame_valid_o,
  output aic_pkg::aic_frame_t     frame_o,
  // Auxiliary bus
  output logic                    scl_o,
  output logic                    scl_oe_o,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  // First interrupt pin
  input  wire logic               irq_src_i,
  input  wire logic               first_irq_pin_i,
  output logic                    first_irq_pin_o,
  output logic                    first_irq_pin_oe_o,
  output logic                    ext_trig_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] fcfg_ff, slv_ff, conf_ff, rdp_ff, wrp_ff, wdat_ff, irq_ff, rbyt_ff;
  logic [7:0] nxt_fcfg, nxt_slv, nxt_conf, nxt_rdp, nxt_wrp, nxt_wdat, nxt_irq;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       busy;
  logic       nack_ff;

  always_comb begin
    nxt_fcfg  = fcfg_ff;
    nxt_slv   = slv_ff;
    nxt_conf  = conf_ff;
    nxt_rdp   = rdp_ff;
    nxt_wrp   = wrp_ff;
    nxt_wdat  = wdat_ff;
    nxt_irq   = irq_ff;
    nxt_rdata = rdata_ff;
    if (we_i) begin
      case (addr_i)
        `AIC_OFS_FCFG: nxt_fcfg = wdata_i & `AIC_MSK_FCFG; // see R1 see R2
        `AIC_OFS_SLV:  nxt_slv  = wdata_i & `AIC_MSK_SLV;  // see R3
        `AIC_OFS_CONF: nxt_conf = wdata_i & `AIC_MSK_CONF; // see R4 see R5
        `AIC_OFS_RDP:  nxt_rdp  = wdata_i;             // see R6
        `AIC_OFS_WRP:  nxt_wrp  = wdata_i;             // see R7
        `AIC_OFS_WDAT: nxt_wdat = wdata_i;             // see R8
        `AIC_OFS_IRQ:  nxt_irq  = wdata_i & `AIC_MSK_IRQ;  // see R9 see R14
        default: ;
      endcase
    end
    if (re_i) begin
      case (addr_i)
        `AIC_OFS_FCFG: nxt_rdata = fcfg_ff;
        `AIC_OFS_SLV:  nxt_rdata = slv_ff;
        `AIC_OFS_CONF: nxt_rdata = conf_ff;
        `AIC_OFS_RDP:  nxt_rdata = rdp_ff;
        `AIC_OFS_WRP:  nxt_rdata = wrp_ff;
        `AIC_OFS_WDAT: nxt_rdata = wdat_ff;
        `AIC_OFS_IRQ:  nxt_rdata = irq_ff;
        `AIC_OFS_STAT: nxt_rdata = {6'h00, nack_ff, busy};
        `AIC_OFS_RBYT: nxt_rdata = rbyt_ff;
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fcfg_ff  <= `AIC_RST_FCFG;
      slv_ff   <= `AIC_RST_SLV;
      conf_ff  <= `AIC_RST_CONF;
      rdp_ff   <= `AIC_RST_RDP;
      wrp_ff   <= `AIC_RST_WRP;
      wdat_ff  <= `AIC_RST_WDAT;
      irq_ff   <= `AIC_RST_IRQ;
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      fcfg_ff  <= nxt_fcfg;
      slv_ff   <= nxt_slv;
      conf_ff  <= nxt_conf;
      rdp_ff   <= nxt_rdp;
      wrp_ff   <= nxt_wrp;
      wdat_ff  <= nxt_wdat;
      irq_ff   <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  logic [2:0] sda_sy_ff, pin_sy_ff;
  logic       sda_in_ff, pin_in_ff;
  logic       nxt_sda_in, nxt_pin_in;

  always_comb begin
    nxt_sda_in = (sda_sy_ff[1] == sda_sy_ff[2]) ? sda_sy_ff[1] : sda_in_ff;
    nxt_pin_in = (pin_sy_ff[1] == pin_sy_ff[2]) ? pin_sy_ff[1] : pin_in_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sy_ff <= 3'h7;
      pin_sy_ff <= 3'h0;
      sda_in_ff <= 1'b1;
      pin_in_ff <= 1'b0;
    end else if (ce_i) begin
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      pin_sy_ff <= {pin_sy_ff[1:0], first_irq_pin_i};
      sda_in_ff <= nxt_sda_in;
      pin_in_ff <= nxt_pin_in;
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  aic_pkg::aic_state_t st_ff, nxt_st;
  logic [15:0] qcnt_ff, nxt_qcnt;
  logic [1:0]  ph_ff, nxt_ph;
  logic [3:0]  bit_ff, nxt_bit;
  logic [3:0]  idx_ff, nxt_idx;
  logic [7:0]  sh_ff, nxt_sh;
  logic        rd_ff, nxt_rd;
  logic [63:0] buf_ff, nxt_buf;
  logic        nxt_nack;
  logic [7:0]  nxt_rbyt;
  logic        aux_done;
  logic [3:0]  blen;
  logic        tick, rx, last_rx, start_rd, start_wr;
  logic [2:0]  rxn;

  always_comb begin
    case (conf_ff[1:0])                                 // see R4
      2'h0:    blen = `AIC_BL_1;
      2'h1:    blen = `AIC_BL_2;
      2'h2:    blen = `AIC_BL_6;
      default: blen = `AIC_BL_8;
    endcase
  end

  function automatic logic [7:0] tx_byte(input logic [3:0] i, input logic r);
    case (i)
      4'h0:    tx_byte = {slv_ff[7:1], 1'b0};          // see R3
      4'h1:    tx_byte = r ? rdp_ff : wrp_ff;         // see R6 see R7
      4'h2:    tx_byte = r ? {slv_ff[7:1], 1'b1} : wdat_ff; // see R3 see R8
      default: tx_byte = 8'hFF;
    endcase
  endfunction

  assign busy     = (st_ff != aic_pkg::ST_IDLE);
  assign tick     = busy && (qcnt_ff == 16'(QTR_CYC - 1));
  assign rx       = rd_ff && (idx_ff >= 4'h3);
  assign rxn      = 3'(idx_ff - 4'h3);
  assign last_rx  = rx && ({1'b0, rxn} + 4'h1 == blen);
  assign start_wr = conf_ff[`AIC_B_MANUAL] && we_i && addr_i == `AIC_OFS_WDAT;   // see R15
  assign start_rd = conf_ff[`AIC_B_MANUAL] ? (we_i && addr_i == `AIC_OFS_RDP)  // see R15
                                           : poll_i;                          // see R5

  always_comb begin
    nxt_st   = st_ff;
    nxt_qcnt = tick ? 16'h0000 : (busy ? qcnt_ff + 16'h0001 : 16'h0000);
    nxt_ph   = tick ? ph_ff + 2'h1 : ph_ff;
    nxt_bit  = bit_ff;
    nxt_idx  = idx_ff;
    nxt_sh   = sh_ff;
    nxt_rd   = rd_ff;
    nxt_buf  = buf_ff;
    nxt_nack = nack_ff;
    nxt_rbyt = rbyt_ff;
    aux_done = 1'b0;
    case (st_ff)
      aic_pkg::ST_IDLE: begin
        if (start_rd || start_wr) begin
          nxt_st   = aic_pkg::ST_START;
          nxt_rd   = start_rd;
          nxt_ph   = 2'h0;
          nxt_nack = 1'b0;
          nxt_buf  = 64'h0;
        end
      end
      aic_pkg::ST_START, aic_pkg::ST_RSTART: begin
        if (tick && ph_ff == 2'h3) begin
          nxt_st  = aic_pkg::ST_BIT;
          nxt_idx = (st_ff == aic_pkg::ST_START) ? 4'h0 : 4'h2;
          nxt_sh  = tx_byte(nxt_idx, rd_ff);
          nxt_bit = 4'h0;
        end
      end
      aic_pkg::ST_BIT: begin
        if (tick && ph_ff == 2'h2) begin
          if (bit_ff != 4'h8 && rx) begin
            nxt_sh = {sh_ff[6:0], sda_in_ff};
          end else if (bit_ff == 4'h8 && !rx) begin
            nxt_nack = sda_in_ff;
          end
        end
        if (tick && ph_ff == 2'h3) begin
          if (bit_ff != 4'h8) begin
            nxt_bit = bit_ff + 4'h1;
            if (!rx) begin
              nxt_sh = {sh_ff[6:0], 1'b1};
            end
          end else begin
            nxt_bit = 4'h0;
            if (rx) begin
              nxt_buf[{rxn, 3'h0} +: 8] = sh_ff;
              nxt_rbyt = sh_ff;
            end
            if (nack_ff || (!rd_ff && idx_ff == 4'h2) || last_rx) begin
              nxt_st = aic_pkg::ST_STOP;
            end else if (rd_ff && idx_ff == 4'h1) begin
              nxt_st = aic_pkg::ST_RSTART;
            end else begin
              nxt_idx = idx_ff + 4'h1;
              nxt_sh  = tx_byte(nxt_idx, rd_ff);
            end
          end
        end
      end
      aic_pkg::ST_STOP: begin
        if (tick && ph_ff == 2'h3) begin
          nxt_st   = aic_pkg::ST_IDLE;
          aux_done = rd_ff && !nack_ff && !conf_ff[`AIC_B_MANUAL];
        end
      end
      default: nxt_st = aic_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff   <= aic_pkg::ST_IDLE;
      qcnt_ff <= 16'h0000;
      ph_ff   <= 2'h0;
      bit_ff  <= 4'h0;
      idx_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      rd_ff   <= 1'b0;
      buf_ff  <= 64'h0;
      nack_ff <= 1'b0;
      rbyt_ff <= 8'h00;
    end else if (ce_i) begin
      st_ff   <= nxt_st;
      qcnt_ff <= nxt_qcnt;
      ph_ff   <= nxt_ph;
      bit_ff  <= nxt_bit;
      idx_ff  <= nxt_idx;
      sh_ff   <= nxt_sh;
      rd_ff   <= nxt_rd;
      buf_ff  <= nxt_buf;
      nack_ff <= nxt_nack;
      rbyt_ff <= nxt_rbyt;
    end
  end

  // ----------------------------------------
  // Bus levels, open drain
  // ----------------------------------------
  logic scl_ff, sda_ff, nxt_scl, nxt_sda;

  always_comb begin
    nxt_scl = 1'b1;
    nxt_sda = 1'b1;
    case (st_ff)
      aic_pkg::ST_START: begin
        nxt_scl = (ph_ff < 2'h2);
        nxt_sda = (ph_ff == 2'h0);
      end
      aic_pkg::ST_RSTART: begin
        nxt_scl = (ph_ff == 2'h1) || (ph_ff == 2'h2);
        nxt_sda = (ph_ff < 2'h2);
      end
      aic_pkg::ST_BIT: begin
        nxt_scl = (ph_ff == 2'h1) || (ph_ff == 2'h2);
        if (bit_ff == 4'h8) begin
          nxt_sda = !rx || last_rx;
        end else begin
          nxt_sda = rx || sh_ff[7];
        end
      end
      aic_pkg::ST_STOP: begin
        nxt_scl = (ph_ff != 2'h0);
        nxt_sda = (ph_ff >= 2'h2);
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else if (ce_i) begin
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
    end
  end

  assign scl_o    = 1'b0;
  assign scl_oe_o = !scl_ff;
  assign sda_o    = 1'b0;
  assign sda_oe_o = !sda_ff;

  // ----------------------------------------
  // FIFO frames
  // ----------------------------------------
  logic                pend_ff, nxt_pend, fval_ff, nxt_fval;
  aic_pkg::aic_frame_t frm_ff, nxt_frm;

  always_comb begin
    nxt_pend = pend_ff;
    nxt_fval = 1'b0;
    nxt_frm  = frm_ff;
    if (acc_valid_i && fcfg_ff[`AIC_B_ACC_EN]) begin           // see R2
      nxt_fval = 1'b1;
      nxt_frm  = '{is_aux: 1'b0, payload: {16'h0000, acc_i}};
    end else if (pend_ff) begin
      nxt_fval = 1'b1;
      nxt_pend = 1'b0;
      nxt_frm  = '{is_aux: 1'b1, payload: buf_ff};
    end
    if (aux_done && fcfg_ff[`AIC_B_AUX_EN]) begin                // see R1
      nxt_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_ff <= 1'b0;
      fval_ff <= 1'b0;
      frm_ff  <= '0;
    end else if (ce_i) begin
      pend_ff <= nxt_pend;
      fval_ff <= nxt_fval;
      frm_ff  <= nxt_frm;
    end
  end

  assign frame_valid_o = fval_ff;
  assign frame_o       = frm_ff;

  // ----------------------------------------
  // First interrupt pin
  // ----------------------------------------
  logic act_lvl, pin_act_ff, nxt_pin_act, trig_ff, nxt_trig;
  logic pout_ff, poe_ff, nxt_pout, nxt_poe;

  always_comb begin
    act_lvl     = irq_src_i ~^ irq_ff[`AIC_B_LVL];                       // see R11
    nxt_pout    = !irq_ff[`AIC_B_OD] && act_lvl;                         // see R12
    nxt_poe     = irq_ff[`AIC_B_OUT_EN] &&                               // see R13
                  (!irq_ff[`AIC_B_OD] || !act_lvl);                      // see R12
    nxt_pin_act = irq_ff[`AIC_B_IN_EN] &&                                // see R14
                  (pin_in_ff ~^ irq_ff[`AIC_B_LVL]);                     // see R11
    nxt_trig    = irq_ff[`AIC_B_EDGE] ? (nxt_pin_act && !pin_act_ff)   // see R10
                                      : nxt_pin_act;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_act_ff <= 1'b0;
      trig_ff    <= 1'b0;
      pout_ff    <= 1'b0;
      poe_ff     <= 1'b0;
    end else if (ce_i) begin
      pin_act_ff <= nxt_pin_act;
      trig_ff    <= nxt_trig;
      pout_ff    <= nxt_pout;
      poe_ff     <= nxt_poe;
    end
  end

  assign first_irq_pin_o    = pout_ff;
  assign first_irq_pin_oe_o = poe_ff;
  assign ext_trig_o         = trig_ff;
endmodule // aic_aux_i2c_cfg

// file: tb/aic_aux_i2c_cfg_asserts.sv
// Checker for the aux I2C master configuration block.
// Bound to aic_aux_i2c_cfg; sees its ports only.
module aic_aux_i2c_cfg_asserts (
  // Clock, reset, register port
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                ce_i,
  input wire logic [7:0]          addr_i,
  input wire logic [7:0]          wdata_i,
  input wire logic                we_i,
  input wire logic                re_i,
  input wire logic [7:0]          rdata_o,
  // Samples and frames
  input wire logic                acc_valid_i,
  input wire aic_pkg::aic_acc_t   acc_i,
  input wire logic                frame_valid_o,
  input wire aic_pkg::aic_frame_t frame_o,
  // Interrupt pin
  input wire logic                irq_src_i,
  input wire logic                first_irq_pin_o,
  input wire logic                first_irq_pin_oe_o,
  input wire logic                ext_trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow of FIFO enables and pin control
  // ----------------------------------------
  logic [1:0] fen_ff;
  logic [1:0] nxt_fen;
  logic [4:0] pin_ff;
  logic [4:0] nxt_pin;
  always_comb begin
    nxt_fen = fen_ff;
    nxt_pin = pin_ff;
    if (we_i && ce_i && addr_i == 8'h49) nxt_fen = wdata_i[6:5];
    if (we_i && ce_i && addr_i == 8'h53) nxt_pin = wdata_i[4:0];
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fen_ff <= 2'h0;
      pin_ff <= 5'h00;
    end else begin
      fen_ff <= nxt_fen;
      pin_ff <= nxt_pin;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  addr_bit0_a: assert property (re_i && ce_i && addr_i == 8'h4B |=> !rdata_o[0])
    else $error("address bit 0 read back set");
  acc_frame_a: assert property (acc_valid_i && ce_i && fen_ff[1] |=> frame_valid_o
    && !frame_o.is_aux && frame_o.payload == {16'h0000, $past(acc_i)})
    else $error("accel frame missing or wrong");
  acc_cause_a: assert property (frame_valid_o && !frame_o.is_aux |->
    $past(acc_valid_i) && $past(fen_ff[1])) else $error("accel frame without cause");
  aux_gate_a: assert property (frame_valid_o && frame_o.is_aux |-> fen_ff[0])
    else $error("aux frame while disabled");
  push_pull_a: assert property (ce_i && !pin_ff[2] |=>
    first_irq_pin_oe_o == $past(pin_ff[3])
    && first_irq_pin_o == ($past(irq_src_i) ~^ $past(pin_ff[1])))
    else $error("push-pull pin wrong");
  open_drain_a: assert property (ce_i && pin_ff[2] |=> !first_irq_pin_o
    && first_irq_pin_oe_o == ($past(pin_ff[3]) && $past(irq_src_i) != $past(pin_ff[1])))
    else $error("open-drain pin wrong");
  trig_off_a: assert property (ce_i && !pin_ff[4] |=> !ext_trig_o)
    else $error("trigger with input disabled");
  edge_pulse_a: assert property (ce_i && pin_ff[4] && pin_ff[0] && ext_trig_o
    |=> !ext_trig_o) else $error("edge trigger longer than one cycle");
  cover property (frame_valid_o && frame_o.is_aux);
  cover property (frame_valid_o && !frame_o.is_aux);
  cover property (ext_trig_o && pin_ff[0]);
endmodule // aic_aux_i2c_cfg_asserts

bind aic_aux_i2c_cfg aic_aux_i2c_cfg_asserts u_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .acc_valid_i(acc_valid_i), .acc_i(acc_i),
  .frame_valid_o(frame_valid_o), .frame_o(frame_o), .irq_src_i(irq_src_i),
  .first_irq_pin_o(first_irq_pin_o), .first_irq_pin_oe_o(first_irq_pin_oe_o),
  .ext_trig_o(ext_trig_o));

// file: tb/aic_i2c_slave_model.sv
// Behavioural I2C sensor on the aux bus; read bytes are pointer plus index.
// Assumes pulled-up wires resolved by the bench.
module aic_i2c_slave_model (
  // Bus levels
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // Refuse the address
  input  wire logic       nack_i,
  // Drive and seen bytes
  output logic            sda_oe_o,
  output logic [7:0]      dev_o,
  output logic [7:0]      ptr_o,
  output logic [7:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  int         nb;
  int         rk;
  logic       rd;
  logic       snd;
  logic [7:0] sh;
  logic [7:0] tx;
  initial begin
    {sda_oe_o, rd, snd, dev_o, ptr_o, dat_o} = '0;
    {cnt, nb, rk} = '0;
  end
  // Start or repeated start
  always @(negedge sda_i) if (scl_i) {cnt, nb, rk, rd, snd} = '0;
  always @(posedge scl_i) begin
    if (cnt < 8 && !snd) sh = {sh[6:0], sda_i};
    if (cnt == 8 && snd && sda_i) begin
      snd = 1'b0;
      nb = 9;
    end
    cnt++;
  end
  always @(negedge scl_i) begin
    if (cnt == 8 && !snd) begin
      if (nb == 0) {dev_o, rd} = {sh, sh[0]};
      else if (nb == 1 && !rd) ptr_o = sh;
      else if (!rd) dat_o = sh;
      nb++;
      sda_oe_o = !nack_i;
    end else if (cnt == 8) sda_oe_o = 1'b0;
    else if (cnt == 9) begin
      cnt = 0;
      sda_oe_o = 1'b0;
      if (rd && nb == 1) snd = 1'b1;
      if (snd) begin
        tx = ptr_o + rk[7:0];
        rk++;
        sda_oe_o = !tx[7];
      end
    end else if (snd && cnt > 0) sda_oe_o = !tx[7-cnt];
  end
endmodule // aic_i2c_slave_model

// file: tb/testbench.sv
// Self-checking bench for the aux I2C master configuration block.
// Assumes the slave model and the bound checker; bus pulled up here.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst_n, ce, we, re, poll, acc_v, irq, pin_i, nack, fv;
  logic                scl_o, scl_oe, sda_o, sda_oe, pin_o, pin_oe, trig, m_oe;
  logic [7:0]          addr, wdata, rdata, dev, ptr, dat;
  aic_pkg::aic_acc_t   acc;
  aic_pkg::aic_frame_t fr;
  logic [7:0]          rq[$];
  logic [64:0]         fq[$];
  logic                rs;
  int                  seed, err_total, total_checks;
  logic [7:0]          ofs[8] = '{8'h49, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h53, 8'h50};
  logic [7:0]          rv[8] = '{8'h00, 8'h20, 8'h83, 8'h42, 8'h4C, 8'h02, 8'h00, 8'h00};
  logic [7:0]          mk[8] = '{8'h60, 8'hFE, 8'h83, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h00};
  logic [7:0]          cf[6] = '{8'h08, 8'h08, 8'h0A, 8'h0E, 8'h0E, 8'h06};
  logic [7:0]          ex[6] = '{8'h02, 8'h03, 8'h03, 8'h00, 8'h02, 8'h00};
  logic                iq[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int                  bl[4] = '{1, 2, 6, 8};
  wire                 scl_w = scl_oe ? scl_o : 1'b1;
  wire                 sda_w = (sda_oe ? sda_o : 1'b1) && !m_oe;

  aic_aux_i2c_cfg #(.QTR_CYC(8)) u_aic_aux_i2c_cfg (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .poll_i(poll), .acc_valid_i(acc_v), .acc_i(acc),
    .frame_valid_o(fv), .frame_o(fr), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_src_i(irq), .first_irq_pin_i(pin_i),
    .first_irq_pin_o(pin_o), .first_irq_pin_oe_o(pin_oe), .ext_trig_o(trig));
  aic_i2c_slave_model u_aic_i2c_slave_model (
    .scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .sda_oe_o(m_oe), .dev_o(dev),
    .ptr_o(ptr), .dat_o(dat));

  // ----------------------------------------
  // Tasks and watchers
  // ----------------------------------------
  task chkr(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkf(input logic [64:0] e, input logic [64:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error frame expected %h seen %h", e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, we} <= {a, d, 1'b1};
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {addr, re} <= {a, 1'b1};
    rq.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask
  task pulse_poll;
    @(posedge clk);
    poll <= 1'b1;
    @(posedge clk);
    poll <= 1'b0;
  endtask
  task wait_idle;
    int i;
    int q;
    q = 0;
    for (i = 0; i < 8000 && q < 100; i++) begin
      @(posedge clk);
      q = (scl_oe !== 1'b0 || sda_oe !== 1'b0) ? 0 : q + 1;
    end
    if (q < 100) begin
      err_total++;
      $display("Error idle expected %0d seen %0d", 100, q);
    end
  endtask
  task wrap_up;
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rs === 1'b1) chkr("rdata", rq.pop_front(), rdata);
    rs <= re;
    if (fv === 1'b1 && fq.size() == 0) begin
      total_checks++;
      err_total++;
      $display("Error frame expected none seen %h", fr);
    end else if (fv === 1'b1) chkf(fq.pop_front(), fr);
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int                i, k, c;
    logic [7:0]        d, p;
    logic [63:0]       pl;
    aic_pkg::aic_acc_t a;
    seed = 71753;
    {rst_n, we, re, poll, acc_v, irq, nack, rs, addr, wdata, acc} = '0;
    {ce, pin_i} = 2'b11;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) rd(ofs[i], rv[i]);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      if (i == 2) d[7] = 1'b0;
      wr(ofs[i], d);
      rd(ofs[i], d & mk[i]);
    end
    p = $random(seed);
    d = $random(seed);
    wr(8'h4B, 8'h3D);
    wr(8'h4C, 8'h80);
    wr(8'h4E, p);
    wr(8'h4F, d);
    wait_idle();
    chkr("addr", 8'h3C, dev);
    chkr("wptr", p, ptr);
    chkr("wdat", d, dat);
    p = $random(seed);
    wr(8'h4C, 8'h81);
    wr(8'h4D, p);
    wait_idle();
    rd(8'h5F, p + 8'h01);
    rd(8'h5E, 8'h00);
    wr(8'h49, 8'h20);
    for (c = 0; c < 4; c++) begin
      p = $random(seed);
      wr(8'h4C, c[7:0]);
      wr(8'h4D, p);
      pl = '0;
      for (k = 0; k < bl[c]; k++) pl[8*k +: 8] = p + k[7:0];
      fq.push_back({1'b1, pl});
      pulse_poll();
      wait_idle();
    end
    wr(8'h49, 8'h00);
    pulse_poll();
    wait_idle();
    wr(8'h49, 8'h40);
    for (k = 0; k < 4; k++) begin
      pl = {$random(seed), $random(seed)};
      a = pl[47:0];
      @(posedge clk);
      {acc_v, acc} <= {1'b1, a};
      fq.push_back({1'b0, 16'h0000, a});
    end
    @(posedge clk);
    acc_v <= 1'b0;
    wr(8'h49, 8'h00);
    @(posedge clk);
    acc_v <= 1'b1;
    @(posedge clk);
    {acc_v, nack} <= 2'b01;
    wr(8'h4C, 8'h80);
    wr(8'h4F, d);
    wait_idle();
    rd(8'h5E, 8'h02);
    nack <= 1'b0;
    for (i = 0; i < 6; i++) begin
      irq <= iq[i];
      wr(8'h53, cf[i]);
      repeat (3) @(posedge clk);
      chkr("pin", ex[i], {6'h00, pin_oe, pin_o});
    end
    wr(8'h53, 8'h10);
    pin_i <= 1'b0;
    repeat (10) @(posedge clk);
    chkr("trig", 8'h01, {7'h00, trig});
    pin_i <= 1'b1;
    repeat (10) @(posedge clk);
    chkr("trig", 8'h00, {7'h00, trig});
    wr(8'h53, 8'h13);
    pin_i <= 1'b0;
    repeat (10) @(posedge clk);
    c = 0;
    pin_i <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      c += trig;
    end
    chkr("pulses", 8'h01, c[7:0]);
    // Frozen enable must drop a write
    ce <= 1'b0;
    wr(8'h4B, 8'h56);
    ce <= 1'b1;
    rd(8'h4B, 8'h3C);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // testbench
